// ### acs_pkg.sv
// Constants, field layout and decode helpers of the converter sequencer.
// Assumes one 125 MHz clock; every file imports this package.
//
// Contract
// - Sequence ignores channel and direction settings.
// - Port reads of analog pins give zero.
// - Digital-configured pins still convert normally.
// - Zero acquisition code defers start one instruction.
// - Code 010 samples four bit periods first.
// - Clearing start bit aborts conversion immediately.
// - Abort leaves result pair untouched.
// - Two bit periods wait after each conversion.
// - Sampling restarts automatically after the wait.
// - Capacitor array discharged before every sample.
// - Main control field positions fixed.
// - Unimplemented control bits read zero.
// - Completion clears start, flags done, resamples.
// - Conversion lasts eleven bit periods.
// - Clock select encodes divisors and RC.
// - Zero acquisition code converts directly; reset value.
package acs_pkg;

  // ==========================================================
  // Register bus and register indexes
  // ==========================================================
  localparam int unsigned AW = 3; // Register address width
  localparam int unsigned DW = 8; // Register data width
  localparam logic [AW-1:0] IDX_RES_LOW = 3'h0; // Result low byte
  localparam logic [AW-1:0] IDX_RES_HIGH = 3'h1; // Result high byte
  localparam logic [AW-1:0] IDX_CTRL_MAIN = 3'h2; // Main control
  localparam logic [AW-1:0] IDX_PIN_CFG = 3'h3; // Pin configuration
  localparam logic [AW-1:0] IDX_TIMING_CFG = 3'h4; // Timing configuration
  localparam logic [AW-1:0] IDX_PORT_READ = 3'h5; // Masked pin levels

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned CM_SEV = 7; // Special event trigger enable
  localparam int unsigned CM_CHS_HI = 3; // Channel select high
  localparam int unsigned CM_CHS_LO = 2; // Channel select low
  localparam int unsigned CM_GO = 1; // Start/status
  localparam int unsigned CM_ON = 0; // Power on
  localparam int unsigned PC_VREF = 4; // Reference source select
  localparam int unsigned PC_CFG_HI = 3; // Analog pin config high
  localparam int unsigned TC_FMT = 7; // Result format select
  localparam int unsigned TC_ACQ_HI = 5; // Acquisition time high
  localparam int unsigned TC_ACQ_LO = 3; // Acquisition time low
  localparam int unsigned TC_CS_HI = 2; // Clock select high
  localparam logic [DW-1:0] CM_MASK = 8'h8F; // Implemented main bits
  localparam logic [DW-1:0] PC_MASK = 8'h1F; // Implemented pin bits
  localparam logic [DW-1:0] TC_MASK = 8'hBF; // Implemented timing bits
  localparam logic [DW-1:0] REG_RESET = 8'h00; // Control reset value

  // ==========================================================
  // Conversion shape and timing
  // ==========================================================
  localparam int unsigned RES_W = 10; // Result width
  localparam int unsigned NPIN = 4; // Analog-capable pins
  localparam int unsigned CW = 5; // Bit-period counter width
  localparam logic [CW-1:0] CONV_TADS = 5'h0B; // Bit periods per conversion
  localparam logic [CW-1:0] WAIT_TADS = 5'h02; // Post-conversion wait
  localparam logic [2:0] INSTR_CYCLES = 3'h4; // Clocks per instruction
  localparam logic [2:0] ACQ_NONE = 3'h0; // Direct conversion code
  localparam logic [RES_W-1:0] SAR_MSB = 10'h200; // First trial bit
  localparam logic [1:0] CS_RC = 2'h3; // Low bits selecting RC source

  typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_DEFER, ST_ACQ, ST_CONV, ST_WAIT} acs_state_e;

  // Acquisition code to bit periods, 2 to 20
  function automatic logic [CW-1:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

  // Clock select to oscillator divisor
  function automatic logic [6:0] clk_div(input logic [2:0] sel);
    case (sel)
      3'h0: clk_div = 7'h02;
      3'h1: clk_div = 7'h08;
      3'h2: clk_div = 7'h20;
      3'h4: clk_div = 7'h04;
      3'h5: clk_div = 7'h10;
      3'h6: clk_div = 7'h40;
      default: clk_div = 7'h02;
    endcase
  endfunction : clk_div

  // Pin n is analog while its config bit is clear
  function automatic logic [NPIN-1:0] analog_mask(input logic [NPIN-1:0] cfg);
    analog_mask = ~cfg;
  endfunction : analog_mask

endpackage : acs_pkg

// ### acs_sync.sv
// Two-stage synchroniser for levels entering from outside the clock.
// Assumes the inputs are slow levels; no pulse shorter than a clock.
`timescale 1ns/1ps
module acs_sync #(
  parameter int unsigned W = 1 // Number of levels
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [W-1:0] d_i, // Asynchronous levels
  output logic [W-1:0] q_o // Synchronised levels
);
  import acs_pkg::*;

  // ==========================================================
  // Stages
  // ==========================================================
  logic [W-1:0] meta_ff; // First stage, read by second only

  // Both stages clear at reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : acs_sync

// ### acs_tad_gen.sv
// Bit-period tick generator: divides the clock or follows the RC source.
// Assumes rc_lvl_i is already synchronised to the clock.
`timescale 1ns/1ps
module acs_tad_gen (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [2:0] sel_i, // Conversion clock select
  input wire logic rc_lvl_i, // Synchronised RC oscillator level
  output logic tick_o // One-cycle pulse per bit period
);
  import acs_pkg::*;

  // ==========================================================
  // Divider and RC edge detect
  // ==========================================================
  logic [6:0] div_cnt_ff; // Divider count
  logic rc_prev_ff; // Previous RC level
  logic use_rc; // RC source selected
  logic div_end; // Divider wraps

  assign use_rc = (sel_i[1:0] == CS_RC);
  assign div_end = (div_cnt_ff >= clk_div(sel_i) - 7'h01);

  // Divider restarts on wrap; a select change takes effect at once
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_cnt_ff <= '0;
    else if (use_rc || div_end)
      div_cnt_ff <= '0;
    else
      div_cnt_ff <= div_cnt_ff + 7'h01;
  end

  // Tick on divider wrap or on each RC rising edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rc_prev_ff <= 1'b0;
      tick_o <= 1'b0;
    end
    else
    begin
      rc_prev_ff <= rc_lvl_i;
      tick_o <= use_rc ? (rc_lvl_i && !rc_prev_ff) : div_end;
    end
  end
endmodule : acs_tad_gen

// ### acs_sequencer.sv
// Converter sequencer top: registers, sample/convert state machine, SAR.
// Assumes an external comparator and DAC; pins and RC clock are async.
`timescale 1ns/1ps
module acs_sequencer (
  input wire logic ref_clk_i, // 125 MHz clock
  input wire logic rst_b_i, // Reset, active low, async
  input wire logic [acs_pkg::AW-1:0] addr_i, // Register index
  input wire logic [acs_pkg::DW-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [acs_pkg::DW-1:0] rdata_o, // Read data, cycle after read
  input wire logic [acs_pkg::NPIN-1:0] pin_lvl_i, // Pin digital levels
  input wire logic comp_i, // Comparator: input above DAC
  input wire logic rc_clk_i, // Internal RC oscillator
  input wire logic special_event_i, // Trigger pulse from PWM logic
  output logic [acs_pkg::RES_W-1:0] dac_code_o, // Trial code to DAC
  output logic [1:0] channel_o, // Selected channel to mux
  output logic sample_o, // Sampling switch closed
  output logic discharge_o, // Capacitor array discharge
  output logic ref_sel_o, // Reference source select
  output logic powered_o, // Analog section powered
  output logic done_o // Conversion done flag pulse
);
  import acs_pkg::*;

  // ==========================================================
  // Reset release
  // ==========================================================
  logic [1:0] rst_sh_ff; // Release shift register
  logic rst_n; // Synchronised reset

  // Assert at once, release after two edges
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sh_ff <= 2'h0;
    else
      rst_sh_ff <= {rst_sh_ff[0], 1'b1};
  end
  assign rst_n = rst_sh_ff[1];

  // ==========================================================
  // Input synchronisers and bit-period ticks
  // ==========================================================
  logic [NPIN-1:0] pin_s; // Synchronised pins
  logic comp_s; // Synchronised comparator
  logic rc_s; // Synchronised RC level
  logic tad_tick; // Bit-period pulse

  acs_sync #(.W(NPIN + 2)) u_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .d_i({pin_lvl_i, comp_i, rc_clk_i}),
    .q_o({pin_s, comp_s, rc_s})
  );

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [DW-1:0] ctrl_ff; // Main control, start bit kept apart
  logic [DW-1:0] pcfg_ff; // Pin configuration
  logic [DW-1:0] tcfg_ff; // Timing configuration
  logic go_ff; // Start/status bit
  logic [DW-1:0] res_lo_ff; // Result low byte
  logic [DW-1:0] res_hi_ff; // Result high byte
  logic wr_ctrl; // Write to main control
  logic power_on; // Converter powered
  logic [2:0] acq_code; // Acquisition time select
  logic complete; // Final decision this cycle
  logic aborted; // Start bit cleared mid-sequence

  assign wr_ctrl = wr_i && (addr_i == IDX_CTRL_MAIN);
  assign power_on = ctrl_ff[CM_ON];
  assign acq_code = tcfg_ff[TC_ACQ_HI:TC_ACQ_LO];

  acs_tad_gen u_tad (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .sel_i(tcfg_ff[TC_CS_HI:0]),
    .rc_lvl_i(rc_s),
    .tick_o(tad_tick)
  );

  // Plain configuration writes; masks keep reserved bits at zero
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= REG_RESET;
      pcfg_ff <= REG_RESET;
      tcfg_ff <= REG_RESET; // Acquisition code 000 after reset
    end
    else if (wr_i)
    begin
      case (addr_i)
        IDX_CTRL_MAIN: ctrl_ff <= wdata_i & CM_MASK & ~(8'h01 << CM_GO);
        IDX_PIN_CFG: pcfg_ff <= wdata_i & PC_MASK;
        IDX_TIMING_CFG: tcfg_ff <= wdata_i & TC_MASK;
        default: ; // Other indexes hold nothing here
      endcase
    end
  end

  // Start bit: software or trigger sets, completion or power-off clears
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      go_ff <= 1'b0;
    else if (wr_ctrl)
      // Gated by present power, so a same-write start is dropped
      go_ff <= wdata_i[CM_GO] && power_on && wdata_i[CM_ON];
    else if (!power_on)
      go_ff <= 1'b0;
    else if (special_event_i && ctrl_ff[CM_SEV])
      go_ff <= 1'b1; // Trigger beats a same-cycle completion
    else if (complete)
      go_ff <= 1'b0;
  end

  // ==========================================================
  // Sample / convert state machine
  // ==========================================================
  acs_state_e state_ff; // Current phase
  acs_state_e nxt_state; // Next phase
  logic [CW-1:0] cnt_ff; // Bit periods in this phase
  logic [2:0] icnt_ff; // Clocks in deferral
  logic cnt_hit; // Tick ending a counted phase

  // Phase transitions; channel and pin direction never enter here
  always_comb
  begin
    nxt_state = state_ff;
    cnt_hit = 1'b0;
    aborted = 1'b0;
    complete = 1'b0;
    case (state_ff)
      ST_OFF:
      begin
        if (power_on)
          nxt_state = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        // Any channel, digital or analog pin, is run
        if (go_ff && acq_code == ACQ_NONE)
          nxt_state = ST_DEFER;
        else if (go_ff)
          nxt_state = ST_ACQ;
      end
      ST_DEFER:
      begin
        // Hold one instruction so the processor can sleep
        if (!go_ff)
          aborted = 1'b1;
        else if (icnt_ff == INSTR_CYCLES - 3'h1)
          nxt_state = ST_CONV;
      end
      ST_ACQ:
      begin
        cnt_hit = tad_tick && (cnt_ff == acq_tads(acq_code) - 5'h01);
        if (!go_ff)
          aborted = 1'b1;
        else if (cnt_hit)
          nxt_state = ST_CONV;
      end
      ST_CONV:
      begin
        cnt_hit = tad_tick && (cnt_ff == CONV_TADS - 5'h01);
        if (!go_ff)
          aborted = 1'b1;
        else if (cnt_hit)
          complete = 1'b1;
      end
      ST_WAIT:
      begin
        cnt_hit = tad_tick && (cnt_ff == WAIT_TADS - 5'h01);
        if (cnt_hit)
          nxt_state = ST_SAMPLE;
      end
      default: nxt_state = ST_OFF;
    endcase
    if (aborted || complete)
      nxt_state = ST_WAIT;
    if (!power_on)
      nxt_state = ST_OFF;
  end

  // Phase register
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // Counters restart on every phase change
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      icnt_ff <= '0;
    end
    else if (nxt_state != state_ff)
    begin
      cnt_ff <= '0;
      icnt_ff <= '0;
    end
    else
    begin
      if (tad_tick)
        cnt_ff <= cnt_ff + 5'h01;
      icnt_ff <= icnt_ff + 3'h1;
    end
  end

  // ==========================================================
  // Successive approximation
  // ==========================================================
  logic [RES_W-1:0] sar_ff; // Trial code
  logic [RES_W-1:0] bit_ff; // Bit under trial, one-hot
  logic [RES_W-1:0] decided; // Code after this decision

  // Comparator low means input below trial: drop the bit
  assign decided = comp_s ? sar_ff : (sar_ff & ~bit_ff);

  // First period settles, the next ten decide one bit each
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar_ff <= '0;
      bit_ff <= '0;
    end
    else if (state_ff != ST_CONV)
    begin
      sar_ff <= SAR_MSB;
      bit_ff <= SAR_MSB;
    end
    else if (tad_tick && cnt_ff != '0)
    begin
      sar_ff <= decided | (bit_ff >> 1);
      bit_ff <= bit_ff >> 1;
    end
  end

  // Result pair: written by software, or only by a full conversion
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_lo_ff <= REG_RESET;
      res_hi_ff <= REG_RESET;
    end
    else if (complete && tcfg_ff[TC_FMT])
    begin
      res_hi_ff <= {6'h00, decided[9:8]};
      res_lo_ff <= decided[7:0];
    end
    else if (complete)
    begin
      res_hi_ff <= decided[9:2];
      res_lo_ff <= {decided[1:0], 6'h00};
    end
    else if (wr_i && addr_i == IDX_RES_HIGH)
      res_hi_ff <= wdata_i; // Abort never reaches here
    else if (wr_i && addr_i == IDX_RES_LOW)
      res_lo_ff <= wdata_i;
  end

  // ==========================================================
  // Analog side outputs
  // ==========================================================
  // Discharge for the first bit period of each sample
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      discharge_o <= 1'b0;
      sample_o <= 1'b0;
    end
    else
    begin
      if (nxt_state == ST_SAMPLE && state_ff != ST_SAMPLE)
        discharge_o <= 1'b1;
      else if (tad_tick || nxt_state != ST_SAMPLE)
        discharge_o <= 1'b0;
      sample_o <= (nxt_state == ST_SAMPLE) || (nxt_state == ST_ACQ);
    end
  end

  // Registered copies for the analog block and the flag pulse
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_code_o <= '0;
      channel_o <= 2'h0;
      ref_sel_o <= 1'b0;
      powered_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      dac_code_o <= sar_ff;
      channel_o <= ctrl_ff[CM_CHS_HI:CM_CHS_LO]; // Pin config never masks it
      ref_sel_o <= pcfg_ff[PC_VREF];
      powered_o <= power_on;
      done_o <= complete;
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  // Data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= '0;
    else if (!rd_i)
      rdata_o <= '0;
    else
    begin
      case (addr_i)
        IDX_RES_LOW: rdata_o <= res_lo_ff;
        IDX_RES_HIGH: rdata_o <= res_hi_ff;
        IDX_CTRL_MAIN: rdata_o <= ctrl_ff | ({7'h00, go_ff} << CM_GO);
        IDX_PIN_CFG: rdata_o <= pcfg_ff;
        IDX_TIMING_CFG: rdata_o <= tcfg_ff;
        // Analog pins read low
        IDX_PORT_READ: rdata_o <= {4'h0, pin_s & ~analog_mask(pcfg_ff[PC_CFG_HI:0])};
        default: rdata_o <= '0;
      endcase
    end
  end
endmodule : acs_sequencer

// ### acs_sequencer_sva.sv
// Checker of the converter sequencer: register copies and sample timing.
// Assumes it is bound to acs_sequencer and sees its ports only.
`timescale 1ns/1ps
module acs_sequencer_sva
  import acs_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic [acs_pkg::AW-1:0] addr_i, // Register index
  input wire logic [acs_pkg::DW-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [acs_pkg::DW-1:0] rdata_o, // Read data
  input wire logic [1:0] channel_o, // Selected channel
  input wire logic sample_o, // Sampling switch
  input wire logic discharge_o, // Array discharge
  input wire logic powered_o, // Power copy
  input wire logic done_o // Done pulse
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [DW-1:0] tc_ff; // Shadow of the timing register
  logic go_wr; // Start write while sampling
  // Shadow kept from bus writes, so acquisition code is known here
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      tc_ff <= REG_RESET;
    else if (wr_i && addr_i == IDX_TIMING_CFG)
      tc_ff <= wdata_i & TC_MASK;
  assign go_wr = wr_i && addr_i == IDX_CTRL_MAIN && wdata_i[1:0] == 2'h3 && powered_o && sample_o;

  // ==========================================================
  // Properties
  // ==========================================================
  property p_rsv_main;
    rd_i && addr_i == IDX_CTRL_MAIN |=> rdata_o[6:4] == 3'h0;
  endproperty
  a_rsv_main: assert property (p_rsv_main) else $error("main control reserved bits set");
  // Lone write shows up on the copies two edges on
  property p_ctrl_copy;
    logic [1:0] ch;
    logic on;
    (wr_i && addr_i == IDX_CTRL_MAIN, ch = wdata_i[3:2], on = wdata_i[0])
      ##1 !(wr_i && addr_i == IDX_CTRL_MAIN) |=> channel_o == ch && powered_o == on;
  endproperty
  a_ctrl_copy: assert property (p_ctrl_copy) else $error("channel or power copy wrong");
  // Three cycles of margin cover the register stages after power off
  property p_off_idle;
    !powered_o && !$past(powered_o) && !$past(powered_o, 2) |-> !sample_o && !done_o;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("activity while powered off");
  property p_done_pulse;
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_post_wait;
    done_o |=> !sample_o [*2];
  endproperty
  a_post_wait: assert property (p_post_wait) else $error("sampling before wait");
  property p_resample;
    done_o |-> ##[2:600] (sample_o && discharge_o);
  endproperty
  a_resample: assert property (p_resample) else $error("sampling not resumed");
  property p_discharge;
    $rose(sample_o) |-> discharge_o;
  endproperty
  a_discharge: assert property (p_discharge) else $error("sample without discharge");
  property p_direct;
    go_wr && tc_ff[5:3] == ACQ_NONE |-> ##[1:2] !sample_o;
  endproperty
  a_direct: assert property (p_direct) else $error("sampling kept with zero code");
  // Four bit periods of eight clocks each, first one partial
  property p_acq4;
    go_wr && tc_ff[5:3] == 3'h2 && tc_ff[2:0] == 3'h1 |=> sample_o [*8] ##[10:30] !sample_o;
  endproperty
  a_acq4: assert property (p_acq4) else $error("acquisition length wrong");
endmodule : acs_sequencer_sva

bind acs_sequencer acs_sequencer_sva u_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .channel_o(channel_o), .sample_o(sample_o), .discharge_o(discharge_o),
  .powered_o(powered_o), .done_o(done_o));

// ### test_acs_sequencer.sv
// Self-checking bench of the converter sequencer over its register port.
// Assumes the checker is bound by its own file; one 125 MHz clock.
`timescale 1ns/1ps
module test_acs_sequencer;
  import acs_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic ref_clk_i = 1'b0; // Clock
  logic rst_b_i = 1'b0; // Reset, active low
  logic [AW-1:0] addr_i = 3'h0; // Register index
  logic [DW-1:0] wdata_i = 8'h00; // Write data
  logic wr_i = 1'b0; // Write strobe
  logic rd_i = 1'b0; // Read strobe
  logic [DW-1:0] rdata_o; // Read data
  logic [NPIN-1:0] pin_lvl_i = 4'h0; // Pin levels
  logic comp_i = 1'b0; // Comparator answer
  logic rc_clk_i = 1'b0; // RC oscillator stand-in
  logic special_event_i = 1'b0; // Trigger pulse
  logic [RES_W-1:0] dac_code_o; // Trial code
  logic [1:0] channel_o; // Channel
  logic sample_o; // Sampling
  logic discharge_o; // Discharge
  logic ref_sel_o; // Reference select
  logic powered_o; // Power copy
  logic done_o; // Done pulse
  logic [RES_W-1:0] target = 10'h000; // Analog level modelled
  int fail_count = 0; // Mismatches
  int checks = 0; // Comparisons
  int cyc = 0; // Cycle counter
  int dones = 0; // Done pulses seen

  acs_sequencer dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_lvl_i(pin_lvl_i),
    .comp_i(comp_i), .rc_clk_i(rc_clk_i), .special_event_i(special_event_i),
    .dac_code_o(dac_code_o), .channel_o(channel_o), .sample_o(sample_o),
    .discharge_o(discharge_o), .ref_sel_o(ref_sel_o), .powered_o(powered_o), .done_o(done_o));

  // ==========================================================
  // Clock, comparator and watchdog
  // ==========================================================
  always #4 ref_clk_i = ~ref_clk_i;
  // Comparator says input at or above the trial code
  always @(posedge ref_clk_i)
    comp_i <= (dac_code_o <= target);
  // Cycle count, done tally, hang limit well above the run
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    rc_clk_i <= cyc[2];
    if (done_o === 1'b1)
      dones <= dones + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata_o});
  endtask : rd
  // Start by write after the post-conversion wait, time it to done
  task automatic conv(input logic [RES_W-1:0] t, input int lo, input int hi);
    int n;
    n = 0;
    repeat (30) @(posedge ref_clk_i);
    target <= t;
    wr(IDX_CTRL_MAIN, 8'h8F);
    while (done_o !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk("conv_cycles", 16'h0001, {15'h0000, n >= lo && n <= hi});
  endtask : conv
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    int n;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++)
      rd(i[AW-1:0], 8'h00, "reset_value");
    wr(IDX_CTRL_MAIN, 8'hFF);
    rd(IDX_CTRL_MAIN, 8'h8D, "ctrl_go_refused");
    // RC bit-period source for the first conversion, divider for the rest
    wr(IDX_TIMING_CFG, 8'hC3);
    rd(IDX_TIMING_CFG, 8'h83, "timing_rsv");
    conv(10'h2A5, 84, 100);
    rd(IDX_RES_HIGH, 8'h02, "res_high_right");
    rd(IDX_RES_LOW, 8'hA5, "res_low_right");
    rd(IDX_CTRL_MAIN, 8'h8D, "go_cleared");
    // Channel 3 on a pin set digital still converts
    wr(IDX_PIN_CFG, 8'h0F);
    wr(IDX_TIMING_CFG, 8'h11);
    conv(10'h1C3, 112, 130);
    rd(IDX_RES_HIGH, 8'h70, "res_high_left");
    rd(IDX_RES_LOW, 8'hC0, "res_low_left");
    // Trigger start, then clear the start bit mid-conversion
    n = dones;
    repeat (30) @(posedge ref_clk_i);
    target <= 10'h3FF;
    special_event_i <= 1'b1;
    @(posedge ref_clk_i);
    special_event_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    wr(IDX_CTRL_MAIN, 8'h8D);
    repeat (200) @(posedge ref_clk_i);
    #1;
    chk("done_after_abort", n[15:0], dones[15:0]);
    chk("resample", 16'h0001, {15'h0000, sample_o});
    rd(IDX_RES_LOW, 8'hC0, "res_kept");
    wr(IDX_RES_LOW, 8'h5A);
    rd(IDX_RES_LOW, 8'h5A, "res_sw_write");
    // Analog pins read low, digital ones show level
    @(posedge ref_clk_i);
    pin_lvl_i <= 4'hF;
    wr(IDX_PIN_CFG, 8'hFA);
    rd(IDX_PIN_CFG, 8'h1A, "pin_rsv");
    rd(IDX_PORT_READ, 8'h0A, "port_analog_zero");
    // Reference select copy follows pin config bit 4
    chk("ref_sel", 16'h0001, {15'h0000, ref_sel_o});
    wr(IDX_CTRL_MAIN, 8'h00);
    wr(IDX_CTRL_MAIN, 8'h02);
    rd(IDX_CTRL_MAIN, 8'h00, "off_ignores_go");
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("off_idle", 16'h0000, {15'h0000, sample_o});
    close_out();
  end
endmodule : test_acs_sequencer
